// *** rtl/bb_rtp_framer.sv ***
`timescale 1ns/1ps
// Summary of operation
// - Timestamp is 22 seconds LSBs then nanosecond MSBs 3 through 12.
// - Send to 239.0.51.48, port 30000 plus the pipe number.
// - Marker is one only on the first packet of a set.
// - Every packet of one set carries the same timestamp.
// - Source identifier holds total byte length when marker is one, else zero.
// - Extension bit is always zero.
// - Contributing-source count is zero and no identifiers follow.
// - Payload type of baseband packets is 78.
// - Padding bit and sequence number behave as ordinary RTP.
// - A set may be split into packets of any size within the MTU.
// - Tunnelled traffic goes in one stream with fixed-size payloads.
// - Column and row parity use separate ports on the same group.
// - Headers of tunnelled packets are never compressed.
// - With parity enabled, XOR parity packets go out with tunnel packets.
// - No control streams are sent beside tunnel and parity streams.
// - Parity streams use tunnel port plus two and plus four.
module bb_rtp_framer import bb_framer_pkg::*; (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Baseband packet descriptor.
  input wire logic desc_valid,
  output logic desc_ready,
  input wire desc_t desc,
  // Baseband payload words.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [31:0] in_data,
  // Configuration, from logic on this clock.
  input wire logic [5:0] seg_words,
  input wire logic fec_enable,
  input wire logic [3:0] fec_cols,
  input wire logic [15:0] tunnel_port,
  // Packet output.
  output logic out_valid,
  input wire logic out_ready,
  output item_t out_item
);

  typedef enum logic [1:0] {S_IDLE, S_HDR, S_PAY, S_FEC} state_t;

  typedef struct packed {
    state_t state;
    pkt_kind_t kind;
    logic [1:0] hdr;
    logic [5:0] idx;
    logic [5:0] seg;
    logic [5:0] seg_len;
    logic tun;
    logic [15:0] nport;
    logic [5:0] pipe;
    logic [31:0] stamp;
    logic [31:0] len;
    logic [29:0] left;
    logic first;
    logic [15:0] seq_d;
    logic [15:0] seq_r;
    logic [15:0] seq_c;
    logic [3:0] grp;
    logic [31:0] row_par;
  } fr_state_t;

  fr_state_t s_reg;
  fr_state_t s_next;
  item_t fr;
  logic fr_valid;
  logic fr_ready;
  logic adv;
  logic wr_en;
  logic [31:0] wr_data;
  logic [MEM_AW-1:0] rd_addr;
  logic [31:0] rd_data;

  // Column parity accumulates here across a group of tunnel packets.
  parity_mem u_mem (
    .clk(clk),
    .wr_en(wr_en),
    .wr_addr(s_reg.idx),
    .wr_data(wr_data),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  // A receiver stall fills this buffer and then holds the framer still.
  two_entry_buffer u_buf (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(fr_valid),
    .in_ready(fr_ready),
    .in_item(fr),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_item(out_item)
  );

  // Framer: header words, payload or padding, then parity packets in tunnel mode.
  always_comb begin
    logic [5:0] limit;
    logic real_word;
    logic done;
    logic marker;
    logic pad_bit;
    limit = s_reg.tun ? s_reg.seg : s_reg.seg_len;
    real_word = (s_reg.idx < s_reg.seg_len);
    done = 1'b0;
    marker = (s_reg.kind == KIND_DATA) && s_reg.first;
    pad_bit = (s_reg.kind == KIND_DATA) && s_reg.tun && (s_reg.seg_len < s_reg.seg);
    s_next = s_reg;
    fr = '0;
    fr_valid = 1'b0;
    desc_ready = 1'b0;
    in_ready = 1'b0;
    wr_en = 1'b0;
    wr_data = '0;
    rd_addr = '0;
    adv = 1'b0;
    fr.route.addr = MCAST_ADDR;
    case (s_reg.kind)
      KIND_ROW: fr.route.port = 16'(s_reg.nport + FEC_ROW_STEP);
      KIND_COL: fr.route.port = 16'(s_reg.nport + FEC_COL_STEP);
      default: fr.route.port = s_reg.tun ? s_reg.nport :
                                16'(PIPE_PORT_BASE + {10'h000, s_reg.pipe});
    endcase
    case (s_reg.state)
      S_IDLE: begin
        desc_ready = 1'b1;
        if (desc_valid) begin
          s_next.pipe = desc.physical_layer_pipe;
          s_next.stamp = stamp_of(desc.secs, desc.nsecs);
          s_next.len = desc.len;
          s_next.left = words_of(desc.len);
          s_next.seg = seg_words;
          s_next.tun = fec_enable;
          s_next.nport = tunnel_port;
          s_next.first = 1'b1;
          s_next.kind = KIND_DATA;
          s_next.hdr = 2'h0;
          s_next.seg_len = seg_take(words_of(desc.len), seg_words);
          s_next.state = (words_of(desc.len) == 30'h0) ? S_IDLE : S_HDR;
        end
      end
      S_HDR: begin
        // Full header on every packet; nothing is ever compressed.
        fr_valid = 1'b1;
        fr.beat.sop = (s_reg.hdr == 2'h0);
        case (s_reg.hdr)
          2'h0: begin
            fr.beat.data = {RTP_VERSION, pad_bit, EXT_BIT, CSRC_COUNT, marker,
                            (s_reg.kind == KIND_DATA) ? PT_BASEBAND : PT_FEC,
                            (s_reg.kind == KIND_DATA) ? s_reg.seq_d :
                            (s_reg.kind == KIND_ROW) ? s_reg.seq_r : s_reg.seq_c};
          end
          2'h1: fr.beat.data = s_reg.stamp;
          default: fr.beat.data = marker ? s_reg.len : 32'h0000_0000;
        endcase
        adv = fr_ready;
        if (adv) begin
          s_next.hdr = 2'(s_reg.hdr + 2'h1);
          if (s_reg.hdr == 2'h0) begin
            // Data, row and column packets count separately, all pipes sharing the data count, so loss shows as a gap.
            case (s_reg.kind)
              KIND_DATA: s_next.seq_d = 16'(s_reg.seq_d + 16'h0001);
              KIND_ROW: s_next.seq_r = 16'(s_reg.seq_r + 16'h0001);
              default: s_next.seq_c = 16'(s_reg.seq_c + 16'h0001);
            endcase
          end
          if (s_reg.hdr == HDR_LAST) begin
            // No contributing-source words: payload follows at once.
            s_next.hdr = 2'h0;
            s_next.idx = 6'h00;
            s_next.state = (s_reg.kind == KIND_DATA) ? S_PAY : S_FEC;
          end
        end
      end
      S_PAY: begin
        fr.beat.eop = (s_reg.idx == 6'(limit - 6'h01));
        if (real_word) begin
          fr_valid = in_valid;
          in_ready = fr_ready;
          fr.beat.data = in_data;
        end else begin
          // Tunnel padding: last word carries the pad byte count, as RTP asks.
          fr_valid = 1'b1;
          fr.beat.data = fr.beat.eop ?
                         {24'h00_0000, 8'({s_reg.seg - s_reg.seg_len, 2'b00})} : 32'h0000_0000;
        end
        adv = fr_valid && fr_ready;
        rd_addr = adv ? 6'(s_reg.idx + 6'h01) : s_reg.idx;
        if (adv) begin
          s_next.idx = 6'(s_reg.idx + 6'h01);
          if (real_word) begin
            s_next.left = 30'(s_reg.left - 30'h1);
          end
          s_next.row_par = (s_reg.idx == 6'h00) ? fr.beat.data : s_reg.row_par ^ fr.beat.data;
          wr_en = s_reg.tun;
          wr_data = (s_reg.grp == 4'h0) ? fr.beat.data : fr.beat.data ^ rd_data;
          done = fr.beat.eop;
        end
      end
      S_FEC: begin
        fr_valid = 1'b1;
        if (s_reg.kind == KIND_ROW) begin
          fr.beat.data = s_reg.row_par;
          fr.beat.eop = 1'b1;
        end else begin
          fr.beat.data = rd_data;
          fr.beat.eop = (s_reg.idx == 6'(s_reg.seg - 6'h01));
        end
        adv = fr_ready;
        rd_addr = adv ? 6'(s_reg.idx + 6'h01) : s_reg.idx;
        if (adv) begin
          s_next.idx = 6'(s_reg.idx + 6'h01);
          done = fr.beat.eop;
        end
      end
      default: s_next.state = S_IDLE;
    endcase
    // Only data, row and column packets exist; no control stream is built.
    if (done) begin
      if (s_reg.kind == KIND_DATA && s_reg.tun) begin
        s_next.kind = KIND_ROW;
        s_next.state = S_HDR;
      end else if (s_reg.kind == KIND_ROW && 4'(s_reg.grp + 4'h1) == fec_cols) begin
        s_next.grp = 4'h0;
        s_next.kind = KIND_COL;
        s_next.state = S_HDR;
      end else begin
        if (s_reg.kind == KIND_ROW) begin
          s_next.grp = 4'(s_reg.grp + 4'h1);
        end
        s_next.kind = KIND_DATA;
        s_next.first = 1'b0;
        s_next.seg_len = seg_take(s_next.left, s_reg.seg);
        s_next.state = (s_next.left == 30'h0) ? S_IDLE : S_HDR;
      end
    end
  end

  // All-zero state is idle with counters cleared.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic hdr_data;
  assign hdr_data = fr_valid && s_reg.state == S_HDR && s_reg.kind == KIND_DATA;

  a_version_field: assert property (fr_valid && fr.beat.sop |->
    fr.beat.data[31:30] == RTP_VERSION) else $error("bad version field");
  a_no_extension: assert property (fr_valid && fr.beat.sop |->
    fr.beat.data[28] == EXT_BIT) else $error("extension bit set");
  a_no_csrc_words: assert property (
    s_reg.state == S_HDR && s_reg.hdr == HDR_LAST && adv |=> s_reg.state inside {S_PAY, S_FEC}
    && s_reg.idx == 6'h00) else $error("extra header words after source id");
  a_payload_type: assert property (hdr_data && s_reg.hdr == 2'h0 |->
    fr.beat.data[22:16] == PT_BASEBAND && fr.beat.data[27:24] == CSRC_COUNT)
    else $error("bad payload type or csrc count");
  a_marker_first: assert property (hdr_data && s_reg.hdr == 2'h0 |->
    fr.beat.data[23] == (s_reg.left == words_of(s_reg.len))) else $error("marker misplaced");
  a_ssrc_length: assert property (hdr_data && s_reg.hdr == HDR_LAST |->
    fr.beat.data == ((s_reg.left == words_of(s_reg.len)) ? s_reg.len : 32'h0000_0000))
    else $error("source id not length or zero");
  a_stamp_bits: assert property (desc_valid && desc_ready |=>
    s_reg.stamp == stamp_of($past(desc.secs), $past(desc.nsecs))) else $error("bad stamp");
  a_stamp_same: assert property (fr_valid && s_reg.state == S_HDR && s_reg.hdr == 2'h1 |->
    fr.beat.data == s_reg.stamp ##1 $stable(s_reg.stamp) || s_reg.state == S_IDLE)
    else $error("timestamp changed within set");
  a_seq_step: assert property (hdr_data && s_reg.hdr == 2'h0 && adv |=>
    s_reg.seq_d == 16'($past(s_reg.seq_d) + 16'h0001)) else $error("sequence did not step");
  a_dest_port: assert property (hdr_data && !s_reg.tun |-> fr.route.addr == MCAST_ADDR &&
    fr.route.port == 16'(PIPE_PORT_BASE + {10'h000, s_reg.pipe})) else $error("bad destination");
  a_fec_ports: assert property (fr_valid && s_reg.kind == KIND_COL |->
    fr.route.port == 16'(s_reg.nport + FEC_COL_STEP)) else $error("bad column port");
  a_fixed_size: assert property (fr_valid && s_reg.state == S_PAY && s_reg.tun |->
    fr.beat.eop == (s_reg.idx == 6'(s_reg.seg - 6'h01))) else $error("tunnel size not fixed");
  a_header_full: assert property (fr_valid && fr_ready && fr.beat.sop |=>
    s_reg.state == S_HDR && s_reg.hdr == 2'h1) else $error("header cut short");

  c_continuation: cover property (hdr_data && s_reg.hdr == 2'h0 && !s_reg.first);
  c_column_fec: cover property (fr_valid && s_reg.kind == KIND_COL && fr.beat.eop);
  c_tunnel_pad: cover property (fr_valid && s_reg.state == S_PAY && s_reg.tun && !(s_reg.idx < s_reg.seg_len));
  c_stall: cover property (fr_valid && !fr_ready [*2]);

endmodule : bb_rtp_framer

// *** rtl/bb_framer_pkg.sv ***
package bb_framer_pkg;

  // Destination of every baseband packet set: multicast group 239.0.51.48.
  localparam logic [31:0] MCAST_ADDR = 32'hEF00_3330;
  // Port of physical layer pipe 0; pipes 0 to 63 map to 30000 to 30063.
  localparam logic [15:0] PIPE_PORT_BASE = 16'h7530;
  // Column and row parity streams sit two and four ports above the tunnel port.
  localparam logic [15:0] FEC_COL_STEP = 16'h0002;
  localparam logic [15:0] FEC_ROW_STEP = 16'h0004;

  // Fixed header fields.
  localparam logic [1:0] RTP_VERSION = 2'h2;
  localparam logic EXT_BIT = 1'h0;
  localparam logic [3:0] CSRC_COUNT = 4'h0;
  localparam logic [6:0] PT_BASEBAND = 7'h4E;
  localparam logic [6:0] PT_FEC = 7'h60;

  // Timestamp field positions: seconds LSBs, then nanosecond MSBs 3 to 12.
  localparam int SEC_MSB = 21;
  localparam int NS_MSB = 29;
  localparam int NS_LSB = 20;

  // Three header words: flags and sequence, timestamp, source identifier.
  localparam logic [1:0] HDR_LAST = 2'h2;

  // Parity memory holds one word for each payload position.
  localparam int MEM_AW = 6;
  localparam int MEM_DEPTH = 64;

  typedef enum logic [1:0] {KIND_DATA, KIND_ROW, KIND_COL} pkt_kind_t;

  typedef struct packed {
    logic [5:0] physical_layer_pipe;
    logic [31:0] secs;
    logic [31:0] nsecs;
    logic [31:0] len;
  } desc_t;

  typedef struct packed {
    logic [31:0] data;
    logic sop;
    logic eop;
  } beat_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [15:0] port;
  } route_t;

  typedef struct packed {
    beat_t beat;
    route_t route;
  } item_t;

  // Frame-identifying timestamp built from the emission time.
  function automatic logic [31:0] stamp_of(input logic [31:0] secs, input logic [31:0] nsecs);
    return {secs[SEC_MSB:0], nsecs[NS_MSB:NS_LSB]};
  endfunction : stamp_of

  // Byte length rounded up to whole 32-bit words.
  function automatic logic [29:0] words_of(input logic [31:0] len);
    return 30'(len[31:2] + {29'h0000_0000, |len[1:0]});
  endfunction : words_of

  // Words carried by the next segment.
  function automatic logic [5:0] seg_take(input logic [29:0] left, input logic [5:0] seg);
    return (left < {24'h00_0000, seg}) ? left[5:0] : seg;
  endfunction : seg_take

endpackage : bb_framer_pkg

// *** rtl/parity_mem.sv ***
`timescale 1ns/1ps
module parity_mem import bb_framer_pkg::*; (
  // Clock.
  input wire logic clk,
  // Write port.
  input wire logic wr_en,
  input wire logic [MEM_AW-1:0] wr_addr,
  input wire logic [31:0] wr_data,
  // Read port, data one cycle after the address.
  input wire logic [MEM_AW-1:0] rd_addr,
  output logic [31:0] rd_data
);

  logic [31:0] mem [MEM_DEPTH];

  // No reset: the first packet of each group overwrites every position the column packet reads.
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule : parity_mem

// *** rtl/two_entry_buffer.sv ***
`timescale 1ns/1ps
module two_entry_buffer import bb_framer_pkg::*; (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire item_t in_item,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output item_t out_item
);

  typedef struct packed {
    item_t e0;
    item_t e1;
    logic [1:0] cnt;
  } buf_state_t;

  buf_state_t s_reg;
  buf_state_t s_next;

  // Ready depends only on the count, so no combinational path runs through.
  assign in_ready = (s_reg.cnt != 2'h2);
  assign out_valid = (s_reg.cnt != 2'h0);
  assign out_item = s_reg.e0;

  // Pop shifts the second entry forward; a push lands behind what remains.
  always_comb begin
    s_next = s_reg;
    if (out_valid && out_ready) begin
      s_next.e0 = s_reg.e1;
      s_next.cnt = 2'(s_next.cnt - 2'h1);
    end
    if (in_valid && in_ready) begin
      if (s_next.cnt == 2'h0) begin
        s_next.e0 = in_item;
      end else begin
        s_next.e1 = in_item;
      end
      s_next.cnt = 2'(s_next.cnt + 2'h1);
    end
  end

  // Empty after reset.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule : two_entry_buffer

// *** test/bb_consumer_model.sv ***
`timescale 1ns/1ps
module bb_consumer_model import bb_framer_pkg::*; (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Packet stream from the framer.
  input wire logic out_valid,
  output logic out_ready,
  input wire item_t out_item,
  // Pacing (0 fast, 1 every other cycle, 2 stalled) and loss of one data packet.
  input wire logic [1:0] mode,
  input wire logic drop_en,
  input wire logic [15:0] drop_seq
);
  logic [31:0] w0_q[$], w1_q[$], w2_q[$], addr_q[$], pay_q[$], cur[$];
  logic [15:0] port_q[$];
  int n_q[$];
  int done_count, drop_count, got, need, idx, pad;
  logic [31:0] h0, h1, h2;
  logic [15:0] prev_seq;
  logic active, seen;

  // Ready moves only on the edge; slow mode halves throughput to exercise the buffer.
  always @(posedge clk) out_ready <= rst_n && mode != 2'h2 && (mode == 2'h0 || !out_ready);

  // Beats are gathered into packets, logged for the bench, then reassembled.
  always @(posedge clk) begin
    if (!rst_n) begin
      idx = 0;
      active = 0;
      seen = 0;
      done_count = 0;
      drop_count = 0;
    end else if (out_valid && out_ready) begin
      if (out_item.beat.sop) idx = 0;
      if (idx == 0) h0 = out_item.beat.data;
      else if (idx == 1) h1 = out_item.beat.data;
      else if (idx == 2) h2 = out_item.beat.data;
      else cur.push_back(out_item.beat.data);
      idx++;
      if (out_item.beat.eop && !(drop_en && h0[22:16] == 7'h4E && h0[15:0] == drop_seq)) begin
        w0_q.push_back(h0);
        w1_q.push_back(h1);
        w2_q.push_back(h2);
        port_q.push_back(out_item.route.port);
        addr_q.push_back(out_item.route.addr);
        n_q.push_back(cur.size());
        foreach (cur[i]) pay_q.push_back(cur[i]);
        pad = h0[29] ? int'(cur[$][7:0]) : 0;
        if (h0[22:16] == 7'h4E) begin
          // Arrival order is taken as sequence order; any other step is a gap.
          if (seen && h0[15:0] != prev_seq + 16'h0001 && active) begin
            active = 0;
            drop_count++;
          end
          // A new marker before the set is complete throws the old set away.
          if (h0[23] && active) drop_count++;
          if (h0[23]) begin
            active = 1;
            got = 0;
            need = h2;
          end
          if (active) begin
            got += 4 * cur.size() - pad;
            if (got >= need) begin
              done_count++;
              active = 0;
            end
          end
          seen = 1;
          prev_seq = h0[15:0];
        end
      end
      if (out_item.beat.eop) cur.delete();
    end
  end
endmodule : bb_consumer_model

// *** test/baseband_packet_rtp_framer_test.sv ***
`timescale 1ns/1ps
module baseband_packet_rtp_framer_test import bb_framer_pkg::*;;
  localparam logic [31:0] full_mask = 32'hFFFF_FFFF;
  // Parity marker and padding bits are left open, so they are masked.
  localparam logic [31:0] par_mask = 32'hDF7F_FFFF;
  logic clk, rst_n, desc_valid, desc_ready, in_valid, in_ready, fec_enable;
  logic out_valid, out_ready, drop_en;
  desc_t desc;
  logic [31:0] in_data;
  logic [5:0] seg_words;
  logic [3:0] fec_cols;
  logic [15:0] tunnel_port, drop_seq, sq;
  logic [1:0] mode;
  item_t out_item;
  logic [31:0] pay[0:63];
  int err_total, num_checks;

  bb_rtp_framer u_bb_rtp_framer (.clk(clk), .rst_n(rst_n), .desc_valid(desc_valid),
    .desc_ready(desc_ready), .desc(desc), .in_valid(in_valid), .in_ready(in_ready),
    .in_data(in_data), .seg_words(seg_words), .fec_enable(fec_enable), .fec_cols(fec_cols),
    .tunnel_port(tunnel_port), .out_valid(out_valid), .out_ready(out_ready),
    .out_item(out_item));

  bb_consumer_model u_bb_consumer_model (.clk(clk), .rst_n(rst_n), .out_valid(out_valid),
    .out_ready(out_ready), .out_item(out_item), .mode(mode), .drop_en(drop_en),
    .drop_seq(drop_seq));

  // Free-running 10 MHz clock.
  always #50 clk = ~clk;

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [31:0] stamp(input logic [31:0] s, input logic [31:0] ns);
    return {s[21:0], ns[29:20]};
  endfunction : stamp

  function automatic logic [31:0] hdr(input logic m, p, input logic [6:0] pt,
                                      input logic [15:0] sn);
    return {2'b10, p, 1'b0, 4'h0, m, pt, sn};
  endfunction : hdr

  // Offers one descriptor, then ceil(len/4) payload words counting up from base.
  task automatic send_set(input logic [5:0] pipe, input logic [31:0] s, ns, len, base);
    desc_valid = 1;
    desc = '{pipe, s, ns, len};
    @(posedge clk);
    while (!desc_ready) @(posedge clk);
    #1 desc_valid = 0;
    for (int i = 0; i < (len + 3) / 4; i++) begin
      in_valid = 1;
      in_data = base + i;
      @(posedge clk);
      while (!in_ready) @(posedge clk);
      #1;
    end
    in_valid = 0;
  endtask : send_set

  // Takes the next logged packet and compares its header, route and size.
  task automatic expect_pkt(input logic [15:0] port, input logic [31:0] w0, w1, w2, m,
                            input int n);
    for (int t = 0; t < 3000 && u_bb_consumer_model.n_q.size() == 0; t++) @(posedge clk);
    #1;
    check(u_bb_consumer_model.w0_q.pop_front() & m, w0 & m);
    check(u_bb_consumer_model.w1_q.pop_front(), w1);
    check(u_bb_consumer_model.w2_q.pop_front(), w2);
    check(u_bb_consumer_model.port_q.pop_front(), port);
    check(u_bb_consumer_model.addr_q.pop_front(), 32'hEF00_3330);
    check(u_bb_consumer_model.n_q.pop_front(), n);
    for (int i = 0; i < n; i++) pay[i] = u_bb_consumer_model.pay_q.pop_front();
  endtask : expect_pkt

  // Ten bytes on pipe 5 in two-word segments: a full packet and a remainder.
  task automatic s_basic;
    int d;
    d = u_bb_consumer_model.done_count;
    seg_words = 6'h02;
    send_set(6'h05, 32'h1234_5678, 32'h2FAF_0800, 32'h0000_000A, 32'hA000_0000);
    expect_pkt(16'h7535, hdr(1, 0, 7'h4E, sq), stamp(32'h1234_5678, 32'h2FAF_0800),
               32'h0000_000A, full_mask, 2);
    expect_pkt(16'h7535, hdr(0, 0, 7'h4E, sq + 16'h0001), stamp(32'h1234_5678, 32'h2FAF_0800),
               32'h0000_0000, full_mask, 1);
    check(pay[0], 32'hA000_0002);
    check(u_bb_consumer_model.done_count, d + 1);
    sq = sq + 16'h0002;
  endtask : s_basic

  // Receiver stalls; the buffer must hold the first word, then back-to-back sets follow.
  task automatic s_stall;
    beat_t held;
    mode = 2'h2;
    seg_words = 6'h3F;
    fork
      send_set(6'h3F, 32'h0000_0001, 32'h0000_0000, 32'h0000_0008, 32'hB000_0000);
      begin
        repeat (20) @(posedge clk);
        #1 held = out_item.beat;
        check(held.sop, 1'b1);
        check(in_ready, 1'b0);
        repeat (10) @(posedge clk);
        #1 check(out_item.beat, held);
        mode = 2'h1;
      end
    join
    send_set(6'h00, 32'h0000_0005, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
    send_set(6'h00, 32'h0000_0006, 32'h3B9A_C9FF, 32'h0000_0004, 32'hB100_0000);
    expect_pkt(16'h756F, hdr(1, 0, 7'h4E, sq), 32'h0000_0400, 32'h0000_0008, full_mask, 2);
    check(pay[1], 32'hB000_0001);
    expect_pkt(16'h7530, hdr(1, 0, 7'h4E, sq + 16'h0001), stamp(32'h0000_0006, 32'h3B9A_C9FF),
               32'h0000_0004, full_mask, 1);
    mode = 2'h0;
    sq = sq + 16'h0002;
  endtask : s_stall

  // Tunnel mode, two-packet column group, three words padded to two fixed segments.
  task automatic s_tunnel;
    logic [31:0] b, ts;
    b = 32'hC000_0010;
    ts = stamp(32'h0000_0002, 32'h1000_0000);
    fec_enable = 1;
    fec_cols = 4'h2;
    tunnel_port = 16'h1388;
    seg_words = 6'h02;
    send_set(6'h07, 32'h0000_0002, 32'h1000_0000, 32'h0000_000C, b);
    expect_pkt(16'h1388, hdr(1, 0, 7'h4E, sq), ts, 32'h0000_000C, full_mask, 2);
    expect_pkt(16'h138C, hdr(0, 0, 7'h60, 16'h0000), ts, 32'h0000_0000, par_mask, 1);
    check(pay[0], b ^ (b + 1));
    expect_pkt(16'h1388, hdr(0, 1, 7'h4E, sq + 16'h0001), ts, 32'h0000_0000, full_mask, 2);
    check(pay[1], 32'h0000_0004);
    expect_pkt(16'h138C, hdr(0, 0, 7'h60, 16'h0001), ts, 32'h0000_0000, par_mask, 1);
    check(pay[0], (b + 2) ^ 32'h0000_0004);
    expect_pkt(16'h138A, hdr(0, 0, 7'h60, 16'h0000), ts, 32'h0000_0000, par_mask, 2);
    check(pay[0], b ^ (b + 2));
    check(pay[1], (b + 1) ^ 32'h0000_0004);
    repeat (20) @(posedge clk);
    #1 check(u_bb_consumer_model.n_q.size(), 0);
    fec_enable = 0;
    fec_cols = 4'h0;
    sq = sq + 16'h0002;
  endtask : s_tunnel

  // The middle packet of a three-packet set is lost; the set must be discarded.
  task automatic s_loss;
    int d, k;
    d = u_bb_consumer_model.done_count;
    k = u_bb_consumer_model.drop_count;
    seg_words = 6'h01;
    drop_seq = sq + 16'h0001;
    drop_en = 1;
    send_set(6'h01, 32'h0000_0003, 32'h0000_0000, 32'h0000_000C, 32'hD000_0000);
    expect_pkt(16'h7531, hdr(1, 0, 7'h4E, sq), 32'h0000_0C00, 32'h0000_000C, full_mask, 1);
    expect_pkt(16'h7531, hdr(0, 0, 7'h4E, sq + 16'h0002), 32'h0000_0C00, 32'h0000_0000, full_mask, 1);
    check(u_bb_consumer_model.drop_count, k + 1);
    check(u_bb_consumer_model.done_count, d);
    drop_en = 0;
  endtask : s_loss

  task automatic final_report;
    $display("checks %0d, mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report

  // Main sequence: reset for four cycles, then every scenario in turn.
  initial begin
    clk = 0;
    rst_n = 0;
    desc_valid = 0;
    desc = '0;
    in_valid = 0;
    in_data = '0;
    seg_words = 6'h02;
    fec_enable = 0;
    fec_cols = 4'h0;
    tunnel_port = 16'h0000;
    mode = 2'h0;
    drop_en = 0;
    drop_seq = 16'h0000;
    err_total = 0;
    num_checks = 0;
    sq = 16'h0000;
    repeat (4) @(posedge clk);
    #1 rst_n = 1;
    s_basic;
    s_stall;
    s_tunnel;
    s_loss;
    final_report;
  end

  // The scenarios need well under 2000 cycles; this cuts a hang short.
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    final_report;
  end
endmodule : baseband_packet_rtp_framer_test
